//--- rtl/pllsc_consts.svh
// pllsc_consts.svh: offsets, field positions, reset values and timing for the pll control regs
`ifndef PLLSC_CONSTS_SVH
`define PLLSC_CONSTS_SVH

`define PLLSC_ADDR_W 12
`define PLLSC_DATA_W 8

// register offsets
`define PLLSC_OFS_ROUTE 12'h085
`define PLLSC_OFS_CTRL 12'h100
`define PLLSC_OFS_CALOPT 12'h101
`define PLLSC_OFS_IRQ_STAT 12'h0F0
`define PLLSC_OFS_IRQ_EN 12'h0F1
`define PLLSC_OFS_IRQ_CLR 12'h0F2

// routing register fields
`define PLLSC_RT_REF1A 0
`define PLLSC_RT_REF1B 1
`define PLLSC_RT_ACTIVE 2
`define PLLSC_RT_PLL2 3
`define PLLSC_RT_PLL3 4
`define PLLSC_RT_INVERT 5
`define PLLSC_RT_HIVOLT 6

// general control fields
`define PLLSC_CT_PWRDN 0
`define PLLSC_CT_CAL 1
`define PLLSC_CT_SYNC 2

// calibration options field
`define PLLSC_CO_OBSERVE 7

// interrupt status bits
`define PLLSC_IRQ_SYNC 0
`define PLLSC_IRQ_CAL 1
`define PLLSC_IRQ_LOSS 2
`define PLLSC_IRQ_W 3

// reset values
`define PLLSC_RST_ROUTE 8'h00
`define PLLSC_RST_CTRL 3'h0
`define PLLSC_RST_OBSERVE 1'h0
`define PLLSC_RST_IRQ 3'h0

// calibration run time
`define PLLSC_CLK_PERIOD_NS 10
`define PLLSC_CAL_TIME_NS 2000
`define PLLSC_CAL_CYCLES (`PLLSC_CAL_TIME_NS / `PLLSC_CLK_PERIOD_NS)

`endif

//--- rtl/pllsc_pkg.sv
// pllsc_pkg: types shared by the pll control register block
`default_nettype none
package pllsc_pkg;

   // loss-of-reference sources, one bit per source as seen on the pins
   typedef struct packed {
      logic active_sel; // 0: first reference active, 1: second reference active
      logic pll3;
      logic pll2;
      logic ref1b;
      logic ref1a;
   } pllsc_loss_t;

   // calibration sequencer states
   typedef enum logic [2:0] {
      PLLSC_CAL_IDLE = 3'b001,
      PLLSC_CAL_RUN = 3'b010,
      PLLSC_CAL_DONE = 3'b100
   } pllsc_cal_state_t;

endpackage
`default_nettype wire

//--- rtl/pllsc_sync2.sv
// pllsc_sync2: two-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
`default_nettype none
module pllsc_sync2 #(
   parameter int W = 5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

//--- rtl/pllsc_cal_seq.sv
// pllsc_cal_seq: vco calibration sequencer for the first pll
`timescale 1ns/100ps
`default_nettype none
`include "pllsc_consts.svh"
module pllsc_cal_seq
   import pllsc_pkg::*;
#(
   parameter int CAL_CYCLES = `PLLSC_CAL_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   output logic busy,
   output logic done
);
   localparam int CW = $clog2(CAL_CYCLES + 1);
   pllsc_cal_state_t state_q;
   logic [CW-1:0] cnt_q;

   // a start during a run is ignored; the sequence always completes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= PLLSC_CAL_IDLE;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            PLLSC_CAL_IDLE: begin
               if (start) begin
                  state_q <= PLLSC_CAL_RUN;
                  cnt_q <= CW'(CAL_CYCLES - 1);
               end
            end
            PLLSC_CAL_RUN: begin
               if (cnt_q == '0) begin
                  state_q <= PLLSC_CAL_DONE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            PLLSC_CAL_DONE: begin
               state_q <= PLLSC_CAL_IDLE;
            end
            default: begin
               state_q <= PLLSC_CAL_IDLE;
            end
         endcase
      end
   end

   assign busy = (state_q == PLLSC_CAL_RUN);
   assign done = (state_q == PLLSC_CAL_DONE);
endmodule
`default_nettype wire

//--- rtl/pllsc_regs.sv
// pllsc_regs: loss-of-reference routing and first-pll general control registers
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "pllsc_consts.svh"

module pllsc_regs
   import pllsc_pkg::*;
#(
   parameter int CAL_CYCLES = `PLLSC_CAL_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [`PLLSC_ADDR_W-1:0] addr,
   input wire logic [`PLLSC_DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [`PLLSC_DATA_W-1:0] rdata,
   input wire pllsc_loss_t loss_of_reference_flag,
   input wire logic out3_clock_level,
   output logic shared_status_output_pin,
   output logic status_pin_static_mode,
   output logic status_pin_hi_voltage,
   output logic pll1_power_down,
   output logic pll1_divider_sync,
   output logic pll1_vco_cal_busy,
   output logic pll1_output_divider_reset,
   output logic irq
);
   logic rst_meta_q;
   logic rst_n;
   pllsc_loss_t loss_s;
   logic [7:0] route_q;
   logic [2:0] ctrl_q;
   logic observe_q;
   logic armed_q;
   logic sync_q;
   logic cal_start_q;
   logic cal_busy;
   logic cal_done;
   logic pin_q;
   logic static_q;
   logic div_rst_q;
   logic loss_any;
   logic loss_prev_q;
   logic [`PLLSC_IRQ_W-1:0] irq_stat_q;
   logic [`PLLSC_IRQ_W-1:0] irq_en_q;
   logic [`PLLSC_IRQ_W-1:0] irq_set;
   logic [`PLLSC_IRQ_W-1:0] irq_clr;
   logic irq_q;
   logic [`PLLSC_DATA_W-1:0] rdata_q;
   logic wr_route;
   logic wr_ctrl;
   logic wr_calopt;
   logic wr_irq_en;
   logic wr_irq_clr;
   logic active_loss;

   // reset released through two flops so all logic leaves reset on one edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // loss flags come from the pll cores on their own clocks
   pllsc_sync2 #(
      .W(5)
   ) u_loss_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(loss_of_reference_flag),
      .q(loss_s)
   );

   // address decode of writes
   assign wr_route = wr_stb && (addr == `PLLSC_OFS_ROUTE);
   assign wr_ctrl = wr_stb && (addr == `PLLSC_OFS_CTRL);
   assign wr_calopt = wr_stb && (addr == `PLLSC_OFS_CALOPT);
   assign wr_irq_en = wr_stb && (addr == `PLLSC_OFS_IRQ_EN);
   assign wr_irq_clr = wr_stb && (addr == `PLLSC_OFS_IRQ_CLR);

   // routing register, reserved bit 7 is not stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         route_q <= `PLLSC_RST_ROUTE;
      end else if (wr_route) begin
         route_q <= {1'b0, wdata[6:0]};
      end
   end

   // general control and calibration options
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `PLLSC_RST_CTRL;
         observe_q <= `PLLSC_RST_OBSERVE;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wdata[2:0];
         end
         if (wr_calopt) begin
            observe_q <= wdata[`PLLSC_CO_OBSERVE];
         end
      end
   end

   // sync arms on a written one and fires when a zero follows while armed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         sync_q <= 1'b0;
         if (wr_ctrl && wdata[`PLLSC_CT_SYNC]) begin
            armed_q <= 1'b1;
         end else if (wr_ctrl && armed_q) begin
            sync_q <= 1'b1;
            armed_q <= 1'b0;
         end
      end
   end

   // calibration starts on a zero-to-one change of the calibrate bit;
   // rewriting a one does not restart a run in progress
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cal_start_q <= 1'b0;
      end else begin
         cal_start_q <= wr_ctrl && wdata[`PLLSC_CT_CAL] && !ctrl_q[`PLLSC_CT_CAL];
      end
   end

   pllsc_cal_seq #(
      .CAL_CYCLES(CAL_CYCLES)
   ) u_cal (
      .clk(clk),
      .rst_n(rst_n),
      .start(cal_start_q),
      .busy(cal_busy),
      .done(cal_done)
   );

   // pick the loss flag of whichever first-pll reference is active
   assign active_loss = loss_s.active_sel ? loss_s.ref1b : loss_s.ref1a;

   // gated loss sources, one enable each
   assign loss_any = (route_q[`PLLSC_RT_PLL3] && loss_s.pll3)
      || (route_q[`PLLSC_RT_PLL2] && loss_s.pll2)
      || (route_q[`PLLSC_RT_ACTIVE] && active_loss)
      || (route_q[`PLLSC_RT_REF1B] && loss_s.ref1b)
      || (route_q[`PLLSC_RT_REF1A] && loss_s.ref1a);

   // shared pin: static loss level when any enable is set, else the clock level;
   // registering the clock adds one cycle of delay, only the static mode is exact
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         static_q <= 1'b0;
         pin_q <= 1'b0;
      end else begin
         static_q <= |route_q[4:0];
         if (|route_q[4:0]) begin
            pin_q <= loss_any ^ route_q[`PLLSC_RT_INVERT];
         end else begin
            pin_q <= out3_clock_level;
         end
      end
   end

   // output divider reset only while calibrating with observe off
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_rst_q <= 1'b0;
      end else begin
         div_rst_q <= cal_busy && !observe_q;
      end
   end

   // interrupt sources: sync fired, calibration finished, routed loss rose
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loss_prev_q <= 1'b0;
      end else begin
         loss_prev_q <= loss_any;
      end
   end

   assign irq_set = {loss_any && !loss_prev_q, cal_done, sync_q};
   assign irq_clr = wr_irq_clr ? wdata[`PLLSC_IRQ_W-1:0] : '0;

   // sticky status; a set in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= `PLLSC_RST_IRQ;
         irq_en_q <= `PLLSC_RST_IRQ;
         irq_q <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
         if (wr_irq_en) begin
            irq_en_q <= wdata[`PLLSC_IRQ_W-1:0];
         end
         irq_q <= |(irq_stat_q & irq_en_q);
      end
   end

   // read data valid in the cycle after the strobe only; unmapped reads zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (rd_stb) begin
         unique case (addr)
            `PLLSC_OFS_ROUTE: rdata_q <= route_q;
            `PLLSC_OFS_CTRL: rdata_q <= {5'h00, ctrl_q};
            `PLLSC_OFS_CALOPT: rdata_q <= {observe_q, 7'h00};
            `PLLSC_OFS_IRQ_STAT: rdata_q <= {5'h00, irq_stat_q};
            `PLLSC_OFS_IRQ_EN: rdata_q <= {5'h00, irq_en_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata = rdata_q;
   assign shared_status_output_pin = pin_q;
   assign status_pin_static_mode = static_q;
   assign status_pin_hi_voltage = route_q[`PLLSC_RT_HIVOLT];
   assign pll1_power_down = ctrl_q[`PLLSC_CT_PWRDN];
   assign pll1_divider_sync = sync_q;
   assign pll1_vco_cal_busy = cal_busy;
   assign pll1_output_divider_reset = div_rst_q;
   assign irq = irq_q;

   property p_pll3_route;
      @(posedge clk) disable iff (!rst_n)
      (route_q[4] && loss_s.pll3 && !route_q[5]) |=> pin_q;
   endproperty
   a_pll3_route: assert property (p_pll3_route) else $error("pll3 loss not on pin");

   property p_pll2_route;
      @(posedge clk) disable iff (!rst_n)
      (route_q[3] && loss_s.pll2 && route_q[5]) |=> !pin_q;
   endproperty
   a_pll2_route: assert property (p_pll2_route) else $error("pll2 loss not on pin");

   property p_active_route;
      @(posedge clk) disable iff (!rst_n)
      (route_q[4:0] == 5'h04 && !route_q[5]) |=> pin_q == $past(active_loss);
   endproperty
   a_active_route: assert property (p_active_route) else $error("active loss wrong");

   property p_ref1b_route;
      @(posedge clk) disable iff (!rst_n)
      (route_q[4:0] == 5'h02 && !route_q[5]) |=> pin_q == $past(loss_s.ref1b);
   endproperty
   a_ref1b_route: assert property (p_ref1b_route) else $error("ref1b loss wrong");

   property p_ref1a_route;
      @(posedge clk) disable iff (!rst_n)
      (route_q[4:0] == 5'h01 && !route_q[5]) |=> pin_q == $past(loss_s.ref1a);
   endproperty
   a_ref1a_route: assert property (p_ref1a_route) else $error("ref1a loss wrong");

   property p_static_mode;
      @(posedge clk) disable iff (!rst_n)
      (route_q[4:0] == 5'h00) |=> !static_q && pin_q == $past(out3_clock_level);
   endproperty
   a_static_mode: assert property (p_static_mode) else $error("pin not in clock mode");

   property p_sync_fire;
      @(posedge clk) disable iff (!rst_n)
      (wr_ctrl && !wdata[2] && armed_q) |=> sync_q ##1 !sync_q;
   endproperty
   a_sync_fire: assert property (p_sync_fire) else $error("sync did not fire once");

   property p_sync_disarm;
      @(posedge clk) disable iff (!rst_n)
      sync_q |-> !armed_q && !$past(sync_q);
   endproperty
   a_sync_disarm: assert property (p_sync_disarm) else $error("sync still armed");

   property p_cal_start;
      @(posedge clk) disable iff (!rst_n)
      (wr_ctrl && wdata[1] && !ctrl_q[1] && !cal_busy) |-> ##[2:2] cal_busy;
   endproperty
   a_cal_start: assert property (p_cal_start) else $error("calibration not started");

   property p_power_down;
      @(posedge clk) disable iff (!rst_n)
      wr_ctrl |=> pll1_power_down == $past(wdata[0]);
   endproperty
   a_power_down: assert property (p_power_down) else $error("power-down wrong");

   property p_div_hold;
      @(posedge clk) disable iff (!rst_n)
      (cal_busy && !observe_q) |=> div_rst_q;
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divider not held");

   property p_div_run;
      @(posedge clk) disable iff (!rst_n)
      observe_q |=> !div_rst_q;
   endproperty
   a_div_run: assert property (p_div_run) else $error("divider held while observing");

   property p_static_on;
      @(posedge clk) disable iff (!rst_n)
      (|route_q[4:0]) |=> static_q;
   endproperty
   a_static_on: assert property (p_static_on) else $error("pin not in static mode");

   property p_sync_needs_arm;
      @(posedge clk) disable iff (!rst_n)
      (wr_ctrl && !armed_q) |=> !sync_q;
   endproperty
   a_sync_needs_arm: assert property (p_sync_needs_arm) else $error("sync fired unarmed");

   property p_pwrdn_hold;
      @(posedge clk) disable iff (!rst_n)
      !wr_ctrl |=> $stable(pll1_power_down);
   endproperty
   a_pwrdn_hold: assert property (p_pwrdn_hold) else $error("power-down moved unwritten");

   property p_div_idle;
      @(posedge clk) disable iff (!rst_n)
      !cal_busy |=> !div_rst_q;
   endproperty
   a_div_idle: assert property (p_div_idle) else $error("divider held while idle");

endmodule
`default_nettype wire

//--- dv/test_pll_status_and_control_regs.sv
// testbench for the loss-of-reference routing and pll1 control registers
`timescale 1ns/100ps
`default_nettype none
`include "pllsc_consts.svh"
module test_pll_status_and_control_regs
   import pllsc_pkg::*;
;
   localparam int CAL_N = 4;
   logic clk;
   logic nrst;
   logic [`PLLSC_ADDR_W-1:0] addr;
   logic [`PLLSC_DATA_W-1:0] wdata;
   logic wr_stb;
   logic rd_stb;
   logic [`PLLSC_DATA_W-1:0] rdata;
   pllsc_loss_t flags;
   logic out3_lvl;
   logic pin;
   logic static_mode;
   logic hi_volt;
   logic pwr_down;
   logic div_sync;
   logic cal_busy;
   logic div_rst;
   logic irq;
   int fail_count;
   int samples_checked;
   int sync_n = 0;
   int busy_n = 0;
   int divr_n = 0;
   int cycles = 0;
   int s0;
   int b0;
   logic [4:0] srcs [5];

   pllsc_regs #(.CAL_CYCLES(CAL_N)) dut_u (
      .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .loss_of_reference_flag(flags),
      .out3_clock_level(out3_lvl), .shared_status_output_pin(pin),
      .status_pin_static_mode(static_mode), .status_pin_hi_voltage(hi_volt),
      .pll1_power_down(pwr_down), .pll1_divider_sync(div_sync),
      .pll1_vco_cal_busy(cal_busy), .pll1_output_divider_reset(div_rst), .irq(irq)
   );

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // pulse and level counters; the cycle counter cuts a hang short
   always @(posedge clk) begin
      if (pll1_ok(div_sync)) sync_n <= sync_n + 1;
      if (pll1_ok(cal_busy)) busy_n <= busy_n + 1;
      if (pll1_ok(div_rst)) divr_n <= divr_n + 1;
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         fail_count = fail_count + 1;
         give_verdict();
      end
   end

   function automatic logic pll1_ok(input logic v);
      return v === 1'b1;
   endfunction

   task automatic give_verdict();
      $display("compares %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one-cycle write, then a quiet cycle so strobes are never reassigned in one step
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      @(posedge clk);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), exp, rdata);
      @(posedge clk);
   endtask

   // flags pass two sync flops and the pin register, so allow a few cycles
   task automatic pin_is(input logic [4:0] f, input logic exp);
      flags <= f;
      repeat (6) @(posedge clk);
      chk("pin", {7'h0, exp}, {7'h0, pin});
   endtask

   initial begin
      srcs = '{5'h01, 5'h02, 5'h01, 5'h04, 5'h08};
      fail_count = 0;
      samples_checked = 0;
      nrst = 1'b0;
      addr = '0;
      wdata = '0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      flags = '0;
      out3_lvl = 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      // reset values, then a write and a read at an unmapped place
      rd(`PLLSC_OFS_ROUTE, 8'h00);
      rd(`PLLSC_OFS_CTRL, 8'h00);
      rd(`PLLSC_OFS_CALOPT, 8'h00);
      rd(`PLLSC_OFS_IRQ_STAT, 8'h00);
      wr(12'h200, 8'hFF);
      rd(12'h200, 8'h00);
      $display("test reset done");
      // each enable passes its own source only
      for (int i = 0; i < 5; i++) begin
         wr(`PLLSC_OFS_ROUTE, 8'h01 << i);
         pin_is(srcs[i], 1'b1);
         chk("static", 8'h01, {7'h0, static_mode});
         pin_is(5'h0F & ~srcs[i], 1'b0);
      end
      // active reference follows the selection
      wr(`PLLSC_OFS_ROUTE, 8'h04);
      pin_is(5'h12, 1'b1);
      pin_is(5'h11, 1'b0);
      // inverted sense, then clock pass-through with static mode off
      wr(`PLLSC_OFS_ROUTE, 8'h29);
      pin_is(5'h00, 1'b1);
      pin_is(5'h01, 1'b0);
      pin_is(5'h04, 1'b0);
      wr(`PLLSC_OFS_ROUTE, 8'h40);
      chk("hivolt", 8'h01, {7'h0, hi_volt});
      out3_lvl <= 1'b1;
      pin_is(5'h0F, 1'b1);
      chk("static", 8'h00, {7'h0, static_mode});
      out3_lvl <= 1'b0;
      pin_is(5'h00, 1'b0);
      rd(`PLLSC_OFS_ROUTE, 8'h40);
      $display("test routing done");
      // loss event latched but masked, then enabled and cleared
      rd(`PLLSC_OFS_IRQ_STAT, 8'h04);
      chk("irq", 8'h00, {7'h0, irq});
      wr(`PLLSC_OFS_IRQ_EN, 8'h07);
      @(posedge clk);
      chk("irq", 8'h01, {7'h0, irq});
      wr(`PLLSC_OFS_IRQ_CLR, 8'h07);
      rd(`PLLSC_OFS_IRQ_CLR, 8'h00);
      rd(`PLLSC_OFS_IRQ_STAT, 8'h00);
      chk("irq", 8'h00, {7'h0, irq});
      $display("test interrupt done");
      // sync fires once per arm-then-zero pair
      s0 = sync_n;
      wr(`PLLSC_OFS_CTRL, 8'h00);
      repeat (3) @(posedge clk);
      chk("sync", 8'h00, 8'(sync_n - s0));
      wr(`PLLSC_OFS_CTRL, 8'h04);
      rd(`PLLSC_OFS_CTRL, 8'h04);
      wr(`PLLSC_OFS_CTRL, 8'h00);
      repeat (3) @(posedge clk);
      chk("sync", 8'h01, 8'(sync_n - s0));
      wr(`PLLSC_OFS_CTRL, 8'h00);
      repeat (3) @(posedge clk);
      chk("sync", 8'h01, 8'(sync_n - s0));
      // a zero sync bit written beside power-down still fires
      wr(`PLLSC_OFS_CTRL, 8'h04);
      wr(`PLLSC_OFS_CTRL, 8'h01);
      repeat (3) @(posedge clk);
      chk("sync", 8'h02, 8'(sync_n - s0));
      chk("pdown", 8'h01, {7'h0, pwr_down});
      rd(`PLLSC_OFS_CTRL, 8'h01);
      wr(`PLLSC_OFS_CTRL, 8'h00);
      chk("pdown", 8'h00, {7'h0, pwr_down});
      $display("test sync done");
      // calibration with divider held, then with divider running
      for (int obs = 0; obs < 2; obs++) begin
         wr(`PLLSC_OFS_CALOPT, obs ? 8'h80 : 8'h00);
         rd(`PLLSC_OFS_CALOPT, obs ? 8'h80 : 8'h00);
         s0 = divr_n;
         b0 = busy_n;
         wr(`PLLSC_OFS_CTRL, 8'h00);
         wr(`PLLSC_OFS_CTRL, 8'h02);
         wr(`PLLSC_OFS_CTRL, 8'h02);
         repeat (CAL_N + 6) @(posedge clk);
         wr(`PLLSC_OFS_CTRL, 8'h00);
         chk("busy", 8'(CAL_N), 8'(busy_n - b0));
         chk("divrst", obs ? 8'h00 : 8'(CAL_N), 8'(divr_n - s0));
      end
      rd(`PLLSC_OFS_IRQ_STAT, 8'h03);
      chk("irq", 8'h01, {7'h0, irq});
      $display("test calibration done");
      give_verdict();
   end
endmodule
`default_nettype wire
